//--- cpu_seq_pkg.sv
// Purpose: Shared constants and types of the machine-cycle sequencer
// Assumes: 16-bit words, byte-addressed memory, word transfers only
// Notes: State codes are one-hot
`default_nettype none
package cpu_seq_pkg;
    localparam int WORD_W = 16;
    localparam logic [15:0] RESET_PC = 16'h0000;
    localparam logic [15:0] RESET_WP = 16'h0080;
    localparam logic [15:0] WORD_STEP = 16'h0002;

    // Instruction fields
    localparam int SRC_REG_LSB = 0;
    localparam int SRC_MODE_LSB = 4;
    localparam int DST_REG_LSB = 6;
    localparam int DST_MODE_LSB = 10;
    localparam int BYTE_BIT = 12;
    localparam logic [1:0] MODE_INDEXED = 2'h2;

    // Opcode groups, bits 15:13 and 15:10
    localparam logic [2:0] OPC3_EXT = 3'h1;
    localparam logic [2:0] OPC3_SZC = 3'h2;
    localparam logic [2:0] OPC3_SUB = 3'h3;
    localparam logic [2:0] OPC3_CMP = 3'h4;
    localparam logic [2:0] OPC3_ADD = 3'h5;
    localparam logic [2:0] OPC3_MOV = 3'h6;
    localparam logic [2:0] OPC3_SOC = 3'h7;
    localparam logic [5:0] OPC6_COC = 6'h08;
    localparam logic [5:0] OPC6_CZC = 6'h09;
    localparam logic [5:0] OPC6_XOR = 6'h0a;
    localparam logic [5:0] OPC6_MPY = 6'h0e;
    localparam logic [5:0] OPC6_DIV = 6'h0f;

    // Iteration counts
    localparam logic [3:0] MUL_LAST = 4'hf;
    localparam logic [3:0] DIV_LAST = 4'hf;

    typedef enum logic [3:0] {
        OP_ADD, OP_SUB, OP_CMP, OP_SOC, OP_SZC, OP_MOV,
        OP_COC, OP_CZC, OP_XOR, OP_MPY, OP_DIV, OP_BAD
    } op_e;

    typedef enum logic [30:0] {
        ST_FETCH  = 31'h00000001,
        ST_DECODE = 31'h00000002,
        ST_SREG   = 31'h00000004,
        ST_XREG   = 31'h00000008,
        ST_XSYM   = 31'h00000010,
        ST_XALU1  = 31'h00000020,
        ST_XDISP  = 31'h00000040,
        ST_XALU2  = 31'h00000080,
        ST_XOPND  = 31'h00000100,
        ST_ALU_S  = 31'h00000200,
        ST_ALU_D  = 31'h00000400,
        ST_WRITE  = 31'h00000800,
        ST_CMPALU = 31'h00001000,
        ST_MREG   = 31'h00002000,
        ST_MALU5  = 31'h00004000,
        ST_MALU6  = 31'h00008000,
        ST_MLOOP  = 31'h00010000,
        ST_MWHI   = 31'h00020000,
        ST_MALU23 = 31'h00040000,
        ST_MWLO   = 31'h00080000,
        ST_DREG   = 31'h00100000,
        ST_DCHK   = 31'h00200000,
        ST_DSKIP  = 31'h00400000,
        ST_DRD2   = 31'h00800000,
        ST_DALU8  = 31'h01000000,
        ST_DALU9  = 31'h02000000,
        ST_DLOOP  = 31'h04000000,
        ST_DALU10 = 31'h08000000,
        ST_DWQ    = 31'h10000000,
        ST_DALU12 = 31'h20000000,
        ST_DWR    = 31'h40000000
    } state_e;
endpackage
`default_nettype wire

//--- two_operand_alu.sv
// Purpose: Result of a two-operand instruction with byte merging
// Assumes: Even byte address selects the upper byte
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
module two_operand_alu
    import cpu_seq_pkg::*;
(
    // Operation
    input wire cpu_seq_pkg::op_e op,
    input wire logic byteOp,
    // Operands
    input wire logic [15:0] srcWord,
    input wire logic [15:0] dstWord,
    input wire logic srcLow,
    input wire logic dstLow,
    // Outcome
    output logic [15:0] result,
    output logic equal
);
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] core;

    always_comb
    begin
        // Bytes run in the upper lane so add and subtract need no extra path
        a = byteOp ? {(srcLow ? srcWord[7:0] : srcWord[15:8]), 8'h00} : srcWord;
        b = byteOp ? {(dstLow ? dstWord[7:0] : dstWord[15:8]), 8'h00} : dstWord;
        case (op)
            OP_ADD: core = b + a;
            OP_SUB: core = b - a;
            OP_SOC: core = b | a;
            OP_SZC: core = b & ~a;
            OP_MOV: core = a;
            OP_XOR: core = b ^ a;
            default: core = b;
        endcase
        case (op)
            OP_COC: equal = (a & b) == a;
            OP_CZC: equal = (a & b) == 16'h0000;
            default: equal = a == b;
        endcase
        // Only the selected byte changes; the neighbour byte is kept
        if (byteOp)
            result = dstLow ? {dstWord[15:8], core[15:8]}
                : {core[15:8], dstWord[7:0]};
        else
            result = core;
    end
endmodule
`default_nettype wire

//--- cpu_machine_cycle_sequencer.sv
// Purpose: Machine-cycle sequencer driving address and data bus per cycle
// Assumes: Memory runs on clk; memReady closes a cycle, low adds wait states
// Notes: Bus values are registered and show one clock after the cycle starts
`timescale 1ns/1ps
`default_nettype none
module cpu_machine_cycle_sequencer
    import cpu_seq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Memory bus
    output logic [15:0] addressBusValue,
    output logic [15:0] dataBusValue,
    output logic memRead,
    output logic memWrite,
    input wire logic [15:0] memRdata,
    input wire logic memReady,
    // Status
    output logic aluCycle,
    output logic instrDone,
    output logic badOpcode,
    output logic statusEqual,
    output logic statusOverflow
);
    import cpu_seq_pkg::*;

    state_e state_r, state_nxt;
    logic phase_r, phase_nxt;
    logic dstPhase_r, dstPhase_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic [15:0] wp_r;
    logic [15:0] ir_r, ir_nxt;
    logic [15:0] addressBusValue_r, addressBusValue_nxt;
    logic [15:0] sourceDataLatch_r, sourceDataLatch_nxt;
    logic [15:0] indexedWorkspaceWord_r, indexedWorkspaceWord_nxt;
    logic [15:0] disp_r, disp_nxt;
    logic [15:0] srcVal_r, srcVal_nxt;
    logic [15:0] srcAddr_r, srcAddr_nxt;
    logic [15:0] dstVal_r, dstVal_nxt;
    logic [15:0] destinationAddress_r, destinationAddress_nxt;
    logic [15:0] result_r, result_nxt;
    logic [15:0] accHi_r, accHi_nxt;
    logic [15:0] accLo_r, accLo_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [1:0] divPh_r, divPh_nxt;
    logic carry_r, carry_nxt;
    logic statusEqual_r, statusEqual_nxt;
    logic statusOverflow_r, statusOverflow_nxt;

    logic memWr;
    logic memCycle;
    logic memEnd;
    logic storeOp;
    logic done;
    logic byteOp;
    logic [3:0] curReg;
    logic [1:0] curMode;
    logic [15:0] memAddr;
    logic [15:0] memData;
    logic [15:0] aluResult;
    logic aluEqual;
    logic [16:0] mulSum;
    op_e opc;

    function automatic logic [15:0] wsAddr(input logic [15:0] wp, input logic [3:0] n);
        wsAddr = wp + {11'h000, n, 1'b0};
    endfunction

    function automatic state_e nextDeriv(input logic [1:0] mode, input logic [3:0] n);
        if (mode != MODE_INDEXED)
            nextDeriv = ST_SREG;
        else if (n == 4'h0)
            nextDeriv = ST_XSYM;
        else
            nextDeriv = ST_XREG;
    endfunction

    function automatic op_e decodeOp(input logic [15:0] w);
        op_e o;
        o = OP_BAD;
        case (w[15:13])
            OPC3_SZC: o = OP_SZC;
            OPC3_SUB: o = OP_SUB;
            OPC3_CMP: o = OP_CMP;
            OPC3_ADD: o = OP_ADD;
            OPC3_MOV: o = OP_MOV;
            OPC3_SOC: o = OP_SOC;
            OPC3_EXT:
            begin
                case (w[15:10])
                    OPC6_COC: o = OP_COC;
                    OPC6_CZC: o = OP_CZC;
                    OPC6_XOR: o = OP_XOR;
                    OPC6_MPY: o = OP_MPY;
                    OPC6_DIV: o = OP_DIV;
                    default: o = OP_BAD;
                endcase
            end
            default: o = OP_BAD;
        endcase
        return o;
    endfunction

    assign opc = decodeOp(ir_r);
    assign byteOp = (ir_r[15:13] >= OPC3_SZC) & ir_r[BYTE_BIT];
    assign curReg = dstPhase_r ? ir_r[DST_REG_LSB +: 4] : ir_r[SRC_REG_LSB +: 4];
    assign curMode = dstPhase_r ? ir_r[DST_MODE_LSB +: 2] : ir_r[SRC_MODE_LSB +: 2];

    assign memWr = state_r inside {ST_WRITE, ST_MWHI, ST_MWLO, ST_DWQ, ST_DWR};
    assign memCycle = memWr | (state_r inside {ST_FETCH, ST_SREG, ST_XREG, ST_XDISP,
        ST_XOPND, ST_MREG, ST_DREG, ST_DRD2});
    // First clock sets up address, strobe from the second until ready
    assign memEnd = memCycle & phase_r & memReady;
    assign memRead = memCycle & ~memWr & phase_r;
    assign memWrite = memWr & phase_r;
    assign aluCycle = ~memCycle;
    assign addressBusValue = addressBusValue_r;
    assign dataBusValue = sourceDataLatch_r;
    assign statusEqual = statusEqual_r;
    assign statusOverflow = statusOverflow_r;
    assign instrDone = done;
    assign badOpcode = (state_r == ST_DECODE) & (opc == OP_BAD);
    assign mulSum = {1'b0, accHi_r} + (accLo_r[0] ? {1'b0, dstVal_r} : 17'h00000);

    two_operand_alu two_operand_alu_inst (
        .op(opc),
        .byteOp(byteOp),
        .srcWord(srcVal_r),
        .dstWord(dstVal_r),
        .srcLow(srcAddr_r[0]),
        .dstLow(destinationAddress_r[0]),
        .result(aluResult),
        .equal(aluEqual)
    );

    always_comb
    begin
        case (state_r)
            ST_FETCH, ST_XDISP: memAddr = pc_r;
            ST_SREG, ST_XREG: memAddr = wsAddr(wp_r, curReg);
            ST_XOPND: memAddr = disp_r + indexedWorkspaceWord_r;
            ST_MREG, ST_DREG: memAddr = wsAddr(wp_r, ir_r[DST_REG_LSB +: 4]);
            ST_WRITE, ST_MWHI, ST_DWQ: memAddr = destinationAddress_r;
            ST_DRD2, ST_MWLO, ST_DWR: memAddr = destinationAddress_r + WORD_STEP;
            default: memAddr = addressBusValue_r;
        endcase
        case (state_r)
            ST_WRITE: memData = result_r;
            ST_MWHI: memData = accHi_r;
            ST_MWLO, ST_DWQ: memData = accLo_r;
            ST_DWR: memData = accHi_r;
            default: memData = sourceDataLatch_r;
        endcase
    end

    always_comb
    begin
        state_nxt = state_r;
        phase_nxt = phase_r;
        dstPhase_nxt = dstPhase_r;
        pc_nxt = pc_r;
        ir_nxt = ir_r;
        addressBusValue_nxt = addressBusValue_r;
        sourceDataLatch_nxt = sourceDataLatch_r;
        indexedWorkspaceWord_nxt = indexedWorkspaceWord_r;
        disp_nxt = disp_r;
        srcVal_nxt = srcVal_r;
        srcAddr_nxt = srcAddr_r;
        dstVal_nxt = dstVal_r;
        destinationAddress_nxt = destinationAddress_r;
        result_nxt = result_r;
        accHi_nxt = accHi_r;
        accLo_nxt = accLo_r;
        cnt_nxt = cnt_r;
        divPh_nxt = divPh_r;
        carry_nxt = carry_r;
        statusEqual_nxt = statusEqual_r;
        statusOverflow_nxt = statusOverflow_r;
        storeOp = 1'b0;
        done = 1'b0;
        if (memCycle && !phase_r)
        begin
            phase_nxt = 1'b1;
            addressBusValue_nxt = {memAddr[15:1], 1'b0};
            if (memWr)
                sourceDataLatch_nxt = memData;
        end
        else if (memEnd || !memCycle)
        begin
            phase_nxt = 1'b0;
            case (state_r)
                ST_FETCH:
                begin
                    ir_nxt = memRdata;
                    pc_nxt = pc_r + WORD_STEP;
                    state_nxt = ST_DECODE;
                end
                ST_DECODE:
                begin
                    dstPhase_nxt = 1'b0;
                    if (opc == OP_BAD)
                        state_nxt = ST_FETCH;
                    else
                        state_nxt = nextDeriv(ir_r[SRC_MODE_LSB +: 2],
                            ir_r[SRC_REG_LSB +: 4]);
                end
                ST_SREG, ST_XOPND: storeOp = 1'b1;
                ST_XREG:
                begin
                    indexedWorkspaceWord_nxt = memRdata;
                    state_nxt = ST_XALU1;
                end
                ST_XSYM:
                begin
                    // Zero index turns the indexed path into the symbolic one
                    indexedWorkspaceWord_nxt = 16'h0000;
                    state_nxt = ST_XALU1;
                end
                ST_XALU1: state_nxt = ST_XDISP;
                ST_XDISP:
                begin
                    disp_nxt = memRdata;
                    pc_nxt = pc_r + WORD_STEP;
                    state_nxt = ST_XALU2;
                end
                ST_XALU2:
                begin
                    // Address bus still holds the displacement address
                    sourceDataLatch_nxt = indexedWorkspaceWord_r;
                    state_nxt = ST_XOPND;
                end
                ST_ALU_S:
                begin
                    dstPhase_nxt = 1'b1;
                    if (opc == OP_MPY)
                        state_nxt = ST_MREG;
                    else if (opc == OP_DIV)
                        state_nxt = ST_DREG;
                    else
                        state_nxt = nextDeriv(ir_r[DST_MODE_LSB +: 2],
                            ir_r[DST_REG_LSB +: 4]);
                end
                ST_ALU_D:
                begin
                    result_nxt = aluResult;
                    if (opc inside {OP_CMP, OP_COC, OP_CZC})
                        state_nxt = ST_CMPALU;
                    else
                        state_nxt = ST_WRITE;
                end
                ST_WRITE: done = 1'b1;
                ST_CMPALU:
                begin
                    addressBusValue_nxt = {destinationAddress_r[15:1], 1'b0};
                    statusEqual_nxt = aluEqual;
                    done = 1'b1;
                end
                ST_MREG, ST_DREG:
                begin
                    dstVal_nxt = memRdata;
                    destinationAddress_nxt = wsAddr(wp_r, ir_r[DST_REG_LSB +: 4]);
                    state_nxt = (state_r == ST_MREG) ? ST_MALU5 : ST_DCHK;
                end
                ST_MALU5: state_nxt = ST_MALU6;
                ST_MALU6:
                begin
                    sourceDataLatch_nxt = srcVal_r;
                    accHi_nxt = 16'h0000;
                    accLo_nxt = srcVal_r;
                    cnt_nxt = 4'h0;
                    state_nxt = ST_MLOOP;
                end
                ST_MLOOP:
                begin
                    accHi_nxt = mulSum[16:1];
                    accLo_nxt = {mulSum[0], accLo_r[15:1]};
                    sourceDataLatch_nxt = mulSum[16:1];
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == MUL_LAST)
                        state_nxt = ST_MWHI;
                end
                ST_MWHI: state_nxt = ST_MALU23;
                ST_MALU23:
                begin
                    addressBusValue_nxt = destinationAddress_r + WORD_STEP;
                    state_nxt = ST_MWLO;
                end
                ST_MWLO, ST_DWR: done = 1'b1;
                ST_DCHK:
                begin
                    sourceDataLatch_nxt = srcVal_r;
                    // Quotient cannot fit when the divisor is not above the high word
                    statusOverflow_nxt = srcVal_r <= dstVal_r;
                    state_nxt = ST_DSKIP;
                end
                ST_DSKIP:
                begin
                    if (statusOverflow_r)
                        done = 1'b1;
                    else
                        state_nxt = ST_DRD2;
                end
                ST_DRD2:
                begin
                    accHi_nxt = dstVal_r;
                    accLo_nxt = memRdata;
                    state_nxt = ST_DALU8;
                end
                ST_DALU8: state_nxt = ST_DALU9;
                ST_DALU9:
                begin
                    cnt_nxt = 4'h0;
                    divPh_nxt = 2'h0;
                    state_nxt = ST_DLOOP;
                end
                ST_DLOOP:
                begin
                    // Two cycles per bit, a third when it subtracts: 32 to 48
                    if (divPh_r == 2'h0)
                    begin
                        carry_nxt = accHi_r[15];
                        accHi_nxt = {accHi_r[14:0], accLo_r[15]};
                        accLo_nxt = {accLo_r[14:0], 1'b0};
                        divPh_nxt = 2'h1;
                    end
                    else if (divPh_r == 2'h1 && (carry_r || accHi_r >= srcVal_r))
                        divPh_nxt = 2'h2;
                    else
                    begin
                        if (divPh_r == 2'h2)
                        begin
                            accHi_nxt = accHi_r - srcVal_r;
                            accLo_nxt = {accLo_r[15:1], 1'b1};
                        end
                        divPh_nxt = 2'h0;
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r == DIV_LAST)
                            state_nxt = ST_DALU10;
                    end
                end
                ST_DALU10: state_nxt = ST_DWQ;
                ST_DWQ: state_nxt = ST_DALU12;
                ST_DALU12:
                begin
                    addressBusValue_nxt = destinationAddress_r + WORD_STEP;
                    state_nxt = ST_DWR;
                end
                default: state_nxt = ST_FETCH;
            endcase
        end
        if (storeOp)
        begin
            if (dstPhase_r)
            begin
                dstVal_nxt = memRdata;
                destinationAddress_nxt = memAddr;
                state_nxt = ST_ALU_D;
            end
            else
            begin
                srcVal_nxt = memRdata;
                srcAddr_nxt = memAddr;
                state_nxt = ST_ALU_S;
            end
        end
        if (done)
            state_nxt = ST_FETCH;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_r <= ST_FETCH;
            phase_r <= 1'b0;
            dstPhase_r <= 1'b0;
            pc_r <= RESET_PC;
            wp_r <= RESET_WP;
            ir_r <= 16'h0000;
            addressBusValue_r <= 16'h0000;
            sourceDataLatch_r <= 16'h0000;
            indexedWorkspaceWord_r <= 16'h0000;
            disp_r <= 16'h0000;
            srcVal_r <= 16'h0000;
            srcAddr_r <= 16'h0000;
            dstVal_r <= 16'h0000;
            destinationAddress_r <= 16'h0000;
            result_r <= 16'h0000;
            accHi_r <= 16'h0000;
            accLo_r <= 16'h0000;
            cnt_r <= 4'h0;
            divPh_r <= 2'h0;
            carry_r <= 1'b0;
            statusEqual_r <= 1'b0;
            statusOverflow_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            dstPhase_r <= dstPhase_nxt;
            pc_r <= pc_nxt;
            ir_r <= ir_nxt;
            addressBusValue_r <= addressBusValue_nxt;
            sourceDataLatch_r <= sourceDataLatch_nxt;
            indexedWorkspaceWord_r <= indexedWorkspaceWord_nxt;
            disp_r <= disp_nxt;
            srcVal_r <= srcVal_nxt;
            srcAddr_r <= srcAddr_nxt;
            dstVal_r <= dstVal_nxt;
            destinationAddress_r <= destinationAddress_nxt;
            result_r <= result_nxt;
            accHi_r <= accHi_nxt;
            accLo_r <= accLo_nxt;
            cnt_r <= cnt_nxt;
            divPh_r <= divPh_nxt;
            carry_r <= carry_nxt;
            statusEqual_r <= statusEqual_nxt;
            statusOverflow_r <= statusOverflow_nxt;
        end
    end
endmodule
`default_nettype wire

//--- cpu_machine_cycle_sequencer_asserts.sv
// Purpose: Bus and sequencing checks on the sequencer's ports
// Assumes: Single clock domain, synchronous reset srst
// Notes: Bound from the bench file
`timescale 1ns/1ps
`default_nettype none
module cpu_seq_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Bus and status
    input wire logic [15:0] addressBusValue,
    input wire logic [15:0] dataBusValue,
    input wire logic memRead,
    input wire logic memWrite,
    input wire logic [15:0] memRdata,
    input wire logic memReady,
    input wire logic aluCycle,
    input wire logic instrDone,
    input wire logic badOpcode,
    input wire logic statusEqual,
    input wire logic statusOverflow
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    strobe_excl_a: assert property (!(memRead && memWrite))
        else $error("read and write strobes together");
    alu_no_strobe_a: assert property (aluCycle |-> !memRead && !memWrite)
        else $error("strobe during ALU cycle");
    wait_hold_a: assert property (memRead && !memReady
        |=> memRead && $stable(addressBusValue))
        else $error("read dropped or address moved in wait state");
    wr_data_hold_a: assert property (memWrite && !memReady |=> $stable(dataBusValue))
        else $error("write data moved in wait state");
    word_align_a: assert property ((memRead || memWrite) |-> !addressBusValue[0])
        else $error("odd address on memory cycle");
    alu_addr_hold_a: assert property (aluCycle [*3] |-> $stable(addressBusValue))
        else $error("address changed in ALU run");
    next_fetch_a: assert property (instrDone |=> !aluCycle && !memRead ##1 memRead)
        else $error("fetch does not follow instruction end");
    one_write_a: assert property (memWrite && memReady |=> !memWrite)
        else $error("write cycles back to back");
    ovf_at_alu_a: assert property ($changed(statusOverflow) |-> $past(aluCycle))
        else $error("overflow flag moved outside ALU cycle");
    cover property (memRead && !memReady);
    cover property (aluCycle [*8]);
    cover property (instrDone && statusOverflow);
endmodule
`default_nettype wire

//--- mem_model.sv
// Purpose: Word memory on the far side of the bus
// Assumes: 256 words, byte addresses
// Notes: Wait states set by the bench
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    // Clock, reset, wait count
    input wire logic clk,
    input wire logic srst,
    input wire logic [1:0] waits,
    // Bus
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic rd,
    input wire logic wr,
    output logic [15:0] rdata,
    output logic ready
);
    logic [15:0] mem [0:255];
    logic [1:0] cnt = 2'h0;
    logic [15:0] last = 16'h0000;
    // Released bus shows inverse of last word, not a stale copy
    assign rdata = rd ? mem[addr[8:1]] : ~last;
    assign ready = (rd || wr) && (cnt == waits);
    always @(posedge clk)
    begin
        if (srst || !(rd || wr) || ready)
            cnt <= 2'h0;
        else
            cnt <= cnt + 2'h1;
        if (wr && ready) mem[addr[8:1]] <= wdata;
        if (rd && ready) last <= mem[addr[8:1]];
    end
endmodule
`default_nettype wire

//--- cpu_machine_cycle_sequencer_bench.sv
// Purpose: Runs one program of two-operand, multiply and divide steps
// Assumes: Workspace at 0x0080, program at 0x0000
// Notes: Registers are set in memory while the next fetch runs
`timescale 1ns/1ps
`default_nettype none
module cpu_machine_cycle_sequencer_bench;
    import cpu_seq_pkg::*;
    logic clk, srst, memRead, memWrite, memReady, aluCycle, instrDone, badOpcode;
    logic statusEqual, statusOverflow;
    logic [15:0] addressBusValue, dataBusValue, memRdata;
    logic [1:0] waits;
    int n_errors = 0, check_count = 0, clocks, nRd, nWr;
    cpu_machine_cycle_sequencer cpu_machine_cycle_sequencer_inst (.clk(clk), .srst(srst),
        .addressBusValue(addressBusValue), .dataBusValue(dataBusValue), .memRead(memRead),
        .memWrite(memWrite), .memRdata(memRdata), .memReady(memReady), .aluCycle(aluCycle),
        .instrDone(instrDone), .badOpcode(badOpcode), .statusEqual(statusEqual),
        .statusOverflow(statusOverflow));
    mem_model mem_model_inst (.clk(clk), .srst(srst), .waits(waits), .addr(addressBusValue),
        .wdata(dataBusValue), .rd(memRead), .wr(memWrite), .rdata(memRdata), .ready(memReady));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic setr(input int n, input logic [15:0] v);
        mem_model_inst.mem[8'h40 + n] = v;
    endtask
    // Samples mid-cycle, so combinational strobes are settled
    task automatic run_instr();
        // Fetch setup clock passes before the first sample
        clocks = 1;
        nRd = 0;
        nWr = 0;
        while (clocks < 300 && instrDone !== 1'b1)
        begin
            @(negedge clk);
            clocks++;
            nRd += int'(memRead & memReady);
            nWr += int'(memWrite & memReady);
        end
        if (instrDone !== 1'b1)
        begin
            check("instr done", 16'(instrDone), 16'h0001);
            end_sim();
        end
        @(negedge clk);
    endtask
    task automatic t_add();
        run_instr();
        check("add", mem_model_inst.mem[8'h42], 16'h3333);
    endtask
    task automatic t_copy_byte_op();
        setr(5, 16'h1234);
        setr(6, 16'habcd);
        run_instr();
        check("copy_byte_op", mem_model_inst.mem[8'h46], 16'h12cd);
        check("copy_byte_op writes", 16'(nWr), 16'h0001);
        check("copy_byte_op reads", 16'(nRd), 16'h0003);
    endtask
    task automatic t_mov();
        setr(7, 16'h5555);
        setr(8, 16'h0f0f);
        run_instr();
        check("mov", mem_model_inst.mem[8'h48], 16'h5555);
        check("mov reads", 16'(nRd), 16'h0003);
    endtask
    task automatic t_index();
        setr(3, 16'h0040);
        setr(4, 16'h0001);
        mem_model_inst.mem[8'ha0] = 16'h0111;
        run_instr();
        check("indexed", mem_model_inst.mem[8'h44], 16'h0112);
        check("indexed reads", 16'(nRd), 16'h0005);
    endtask
    task automatic t_cmp();
        setr(9, 16'h5a5a);
        setr(10, 16'h5a5a);
        run_instr();
        check("cmp writes", 16'(nWr), 16'h0000);
        check("cmp equal", 16'(statusEqual), 16'h0001);
    endtask
    task automatic t_mpy();
        setr(11, 16'h1234);
        setr(12, 16'h0010);
        run_instr();
        check("mpy hi", mem_model_inst.mem[8'h4c], 16'h0001);
        check("mpy lo", mem_model_inst.mem[8'h4d], 16'h2340);
        check("mpy writes", 16'(nWr), 16'h0002);
    endtask
    task automatic t_divov();
        setr(1, 16'h0001);
        setr(14, 16'h0005);
        run_instr();
        check("ovf writes", 16'(nWr), 16'h0000);
        check("ovf flag", 16'(statusOverflow), 16'h0001);
    endtask
    task automatic t_div();
        setr(1, 16'h0010);
        setr(2, 16'h0000);
        setr(3, 16'h0123);
        run_instr();
        check("quotient", mem_model_inst.mem[8'h42], 16'h0012);
        check("remainder", mem_model_inst.mem[8'h43], 16'h0003);
        check("div clocks", 16'(clocks >= 52 && clocks <= 68), 16'h0001);
        check("no ovf", 16'(statusOverflow), 16'h0000);
    endtask
    task automatic t_wait();
        waits = 2'h2;
        setr(1, 16'h0001);
        setr(2, 16'h0002);
        run_instr();
        check("wait add", mem_model_inst.mem[8'h42], 16'h0003);
        check("wait clocks", 16'(clocks), 16'd19);
        waits = 2'h0;
    endtask
    // Word after the program is zero, an unsupported opcode
    task automatic t_bad();
        int n = 0;
        while (n < 20 && badOpcode !== 1'b1)
        begin
            @(negedge clk);
            n++;
        end
        check("bad opcode", 16'(badOpcode), 16'h0001);
    endtask
    initial
    begin
        logic [15:0] prog [0:9];
        prog = '{16'ha081, 16'hd185, 16'hc207, 16'ha123, 16'h0100, 16'h8289, 16'h3b0b,
            16'h3f81, 16'h3c81, 16'ha081};
        srst = 1'b1;
        waits = 2'h0;
        for (int i = 0; i < 256; i++)
            mem_model_inst.mem[i] = (i < 10) ? prog[i] : 16'h0000;
        setr(1, 16'h1111);
        setr(2, 16'h2222);
        repeat (3) @(negedge clk);
        srst = 1'b0;
        t_add();
        t_copy_byte_op();
        t_mov();
        t_index();
        t_cmp();
        t_mpy();
        t_divov();
        t_div();
        t_wait();
        t_bad();
        end_sim();
    end
endmodule
bind cpu_machine_cycle_sequencer cpu_seq_checker cpu_seq_checker_inst (.clk(clk), .srst(srst),
    .addressBusValue(addressBusValue), .dataBusValue(dataBusValue), .memRead(memRead),
    .memWrite(memWrite), .memRdata(memRdata), .memReady(memReady), .aluCycle(aluCycle),
    .instrDone(instrDone), .badOpcode(badOpcode), .statusEqual(statusEqual),
    .statusOverflow(statusOverflow));
`default_nettype wire
